// >>> verilog/tlc_pkg.sv
// tlc_pkg: register map, field layout and reset values of the
// transceiver lane control bank.
// assumes a 32-bit apb slave decoding the low 12 address bits.
package tlc_pkg;

  // ---------------------------------------------------------------
  // address map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] ADDR_LANE_COUNT = 12'h00c;
  localparam logic [11:0] ADDR_LANE_SEL   = 12'h024;
  localparam logic [11:0] ADDR_MB_ADDR    = 12'h104;
  localparam logic [11:0] ADDR_MB_WDATA   = 12'h108;
  localparam logic [11:0] ADDR_MB_RDATA   = 12'h10c;
  localparam logic [11:0] ADDR_MB_STATUS  = 12'h110;
  localparam logic [11:0] ADDR_TX_RST     = 12'h400;
  localparam logic [11:0] ADDR_RX_RST     = 12'h404;
  localparam logic [11:0] ADDR_TX_PWR     = 12'h408;
  localparam logic [11:0] ADDR_SWING      = 12'h40c;
  localparam logic [11:0] ADDR_TX_BLOCK   = 12'h410;
  localparam logic [11:0] ADDR_TX_INV     = 12'h414;
  localparam logic [11:0] ADDR_RX_INV     = 12'h418;
  localparam logic [11:0] ADDR_EQ_SEL     = 12'h41c;
  localparam logic [11:0] ADDR_ADAPT_RST  = 12'h420;
  localparam logic [11:0] ADDR_HDR_LIMIT  = 12'h424;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned LANE_SEL_W    = 8;
  localparam int unsigned MB_DATA_W     = 16;
  localparam int unsigned MB_WR_FLAG    = 31;
  localparam int unsigned MB_RD_FLAG    = 30;
  localparam logic [1:0]  PWR_NORMAL    = 2'h0;
  localparam logic [1:0]  PWR_LOWEST    = 2'h3;
  localparam logic [3:0]  SWING_RST     = 4'hc;
  localparam logic        TX_BLOCK_RST  = 1'h0;
  localparam logic        EQ_SEL_RST    = 1'h1;
  localparam logic [3:0]  HDR_LIMIT_RST = 4'h8;
  localparam logic [3:0]  HDR_LIMIT_MIN = 4'h1;
  localparam logic [3:0]  HDR_LIMIT_MAX = 4'h8;
  // wait states added to accesses bound for the lanes
  localparam logic [3:0]  XING_CYCLES   = 4'h3;

endpackage : tlc_pkg

// >>> verilog/tlc_lane.sv
// tlc_lane: serial edge of one lane, tx inhibit/invert, rx invert.
// assumes tx_bit comes from pclk logic, rx_line_pos from a pin.
`timescale 1ns/100ps
`default_nettype none
module tlc_lane (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tx_bit,
  input  wire logic tx_invert,
  input  wire logic tx_output_block,
  input  wire logic rx_line_pos,
  input  wire logic rx_invert,
  output logic      serial_out_pos,
  output logic      serial_out_neg,
  output logic      rx_bit
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sync;
    logic       pos;
    logic       neg;
    logic       rx;
  } tlc_lane_s;

  tlc_lane_s st;
  tlc_lane_s next_st;

  // inhibit overrides polarity: the line parks at pos=0 neg=1
  always_comb begin
    next_st      = st;
    next_st.sync = {st.sync[0], rx_line_pos};
    if (tx_output_block) begin
      next_st.pos = 1'h0;
      next_st.neg = 1'h1;
    end else begin
      next_st.pos = tx_bit ^ tx_invert;
      next_st.neg = ~(tx_bit ^ tx_invert);
    end
    next_st.rx = st.sync[1] ^ rx_invert;
  end

  // idle line level while reset is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st     <= '0;
      st.neg <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  assign serial_out_pos = st.pos;
  assign serial_out_neg = st.neg;
  assign rx_bit         = st.rx;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_BLOCK_PARKS: assert property (
    @(posedge pclk) disable iff (!presetn)
    tx_output_block |=> (!serial_out_pos && serial_out_neg))
    else $error("inhibited lane not parked");

  AST_TX_INVERT: assert property (
    @(posedge pclk) disable iff (!presetn)
    !tx_output_block |=>
      (serial_out_pos == ($past(tx_bit) ^ $past(tx_invert)))
      && (serial_out_neg != serial_out_pos))
    else $error("tx polarity wrong");

  AST_RX_INVERT: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##3 (rx_bit == ($past(rx_line_pos, 3) ^ $past(rx_invert))))
    else $error("rx polarity wrong");

endmodule : tlc_lane
`default_nettype wire

// >>> verilog/tlc_bank.sv
// tlc_bank: apb register bank controlling the transceiver lanes,
// with shared resets, per-lane fields and a config port mailbox.
// assumes an apb master on pclk and a config port on pclk too.
//
// Summary of operation
// - writing one to tx reset bit 0 holds tx path and pll in reset.
// - writing one to rx reset bit 0 resets rx path and pll.
// - one tx and one rx reset register, shared, any select value.
// - two-bit tx power field, reset zero; 00 normal, 11 lowest.
// - drive swing resets to 1100, width set per transceiver type.
// - inhibit high parks serial output at pos low, neg high.
// - tx invert bit, reset zero, swaps outgoing line senses.
// - rx invert bit, reset zero, inverts incoming data.
// - equalizer select resets one; zero feedback, one low power.
// - bad header limit resets to 8; only 1 to 8 accepted.
// - rate switching mailbox works only when built with that option.
// - mailbox reaches the whole config address space of each block.
// - lane accesses pass a crossing and take extra wait states.
`timescale 1ns/100ps
`default_nettype none
module tlc_bank #(
  parameter int unsigned LANES        = 4,
  parameter int unsigned SWING_W      = 4,
  parameter int unsigned CFG_AW       = 16,
  parameter bit          DYNAMIC_RATE = 1'b1
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [tlc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [LANES-1:0]           tx_bit,
  input  wire logic [LANES-1:0]           rx_line_pos,
  output logic      [LANES-1:0]           serial_out_pos,
  output logic      [LANES-1:0]           serial_out_neg,
  output logic      [LANES-1:0]           rx_bit,
  output logic                            tx_chan_reset,
  output logic                            rx_chan_reset,
  output logic      [2*LANES-1:0]         tx_power_state,
  output logic      [SWING_W*LANES-1:0]   tx_drive_swing,
  output logic      [LANES-1:0]           rx_equalizer_select,
  output logic      [LANES-1:0]           rx_adapt_reset,
  output logic      [4*LANES-1:0]         rx_bad_header_limit,
  output logic                            cfg_en,
  output logic                            cfg_we,
  output logic      [7:0]                 cfg_sel,
  output logic      [CFG_AW-1:0]          cfg_addr,
  output logic      [15:0]                cfg_wdata,
  input  wire logic [15:0]                cfg_rdata,
  input  wire logic                       cfg_rdy
);

  localparam int unsigned IW = (LANES > 1) ? $clog2(LANES) : 1;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic {MB_IDLE, MB_BUSY} tlc_mb_e;

  typedef struct packed {
    logic [tlc_pkg::LANE_SEL_W-1:0] sel;
    logic                           tx_rst;
    logic                           rx_rst;
    logic [LANES-1:0][1:0]          pwr;
    logic [LANES-1:0][SWING_W-1:0]  swing;
    logic [LANES-1:0]               blk;
    logic [LANES-1:0]               tinv;
    logic [LANES-1:0]               rinv;
    logic [LANES-1:0]               eq;
    logic [LANES-1:0]               adrst;
    logic [LANES-1:0][3:0]          hdr;
    logic [3:0]                     wait_cnt;
    logic [31:0]                    rdata;
    tlc_mb_e                        mb;
    logic                           mb_go;
    logic                           mb_we;
    logic [CFG_AW-1:0]              mb_addr;
    logic [15:0]                    mb_wdata;
    logic [15:0]                    mb_rdata;
  } tlc_bank_s;

  tlc_bank_s   st;
  tlc_bank_s   next_st;
  logic [31:0] rd;
  logic        hit;
  logic        lane_hit;
  logic        xing;
  logic        sel_ok;
  logic        wr;
  logic [IW-1:0] idx;

  assign idx    = st.sel[IW-1:0];
  assign sel_ok = st.sel < tlc_pkg::LANE_SEL_W'(LANES);

  // ---------------------------------------------------------------
  // address decode and read mux
  // ---------------------------------------------------------------
  // reads of lane fields see only the selected lane's copy
  always_comb begin
    rd       = '0;
    hit      = 1'b1;
    lane_hit = 1'b0;
    xing     = 1'b0;
    case (paddr)
      tlc_pkg::ADDR_LANE_COUNT: rd = 32'(LANES);
      tlc_pkg::ADDR_LANE_SEL:   rd[7:0] = st.sel;
      tlc_pkg::ADDR_MB_ADDR:    rd[CFG_AW-1:0] = st.mb_addr;
      tlc_pkg::ADDR_MB_WDATA:   rd[15:0] = st.mb_wdata;
      tlc_pkg::ADDR_MB_RDATA:   rd[15:0] = st.mb_rdata;
      tlc_pkg::ADDR_MB_STATUS:  rd[0] = (st.mb == MB_BUSY);
      tlc_pkg::ADDR_TX_RST: begin
        rd[0] = st.tx_rst;
        xing  = 1'b1;
      end
      tlc_pkg::ADDR_RX_RST: begin
        rd[0] = st.rx_rst;
        xing  = 1'b1;
      end
      tlc_pkg::ADDR_TX_PWR,
      tlc_pkg::ADDR_SWING,
      tlc_pkg::ADDR_TX_BLOCK,
      tlc_pkg::ADDR_TX_INV,
      tlc_pkg::ADDR_RX_INV,
      tlc_pkg::ADDR_EQ_SEL,
      tlc_pkg::ADDR_ADAPT_RST,
      tlc_pkg::ADDR_HDR_LIMIT: begin
        lane_hit = 1'b1;
        xing     = 1'b1;
        if (sel_ok) begin
          case (paddr)
            tlc_pkg::ADDR_TX_PWR:    rd[1:0] = st.pwr[idx];
            tlc_pkg::ADDR_SWING:     rd[SWING_W-1:0] = st.swing[idx];
            tlc_pkg::ADDR_TX_BLOCK:  rd[0] = st.blk[idx];
            tlc_pkg::ADDR_TX_INV:    rd[0] = st.tinv[idx];
            tlc_pkg::ADDR_RX_INV:    rd[0] = st.rinv[idx];
            tlc_pkg::ADDR_EQ_SEL:    rd[0] = st.eq[idx];
            tlc_pkg::ADDR_ADAPT_RST: rd[0] = st.adrst[idx];
            default:                 rd[3:0] = st.hdr[idx];
          endcase
        end
      end
      default: hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  // a bad lane index errors rather than touching a random lane
  assign pready  = psel & penable & (st.wait_cnt == 4'h0);
  assign pslverr = pready & (~hit | (lane_hit & ~sel_ok));
  assign wr      = pready & pwrite & ~pslverr;
  assign prdata  = st.rdata;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.mb_go = 1'b0;
    // wait states stand in for the trip into the lane domains
    if (psel && !penable) begin
      next_st.wait_cnt = xing ? tlc_pkg::XING_CYCLES : 4'h0;
    end else if (psel && st.wait_cnt != 4'h0) begin
      next_st.wait_cnt = st.wait_cnt - 4'h1;
    end
    if (psel) begin
      next_st.rdata = rd;
    end
    // mailbox completion; a read captures the returned word
    if (st.mb == MB_BUSY && cfg_rdy) begin
      next_st.mb = MB_IDLE;
      if (!st.mb_we) begin
        next_st.mb_rdata = cfg_rdata;
      end
    end
    if (wr) begin
      case (paddr)
        tlc_pkg::ADDR_LANE_SEL: next_st.sel = pwdata[7:0];
        tlc_pkg::ADDR_TX_RST:   next_st.tx_rst = pwdata[0];
        tlc_pkg::ADDR_RX_RST:   next_st.rx_rst = pwdata[0];
        tlc_pkg::ADDR_TX_PWR:   next_st.pwr[idx] = pwdata[1:0];
        tlc_pkg::ADDR_SWING:
          next_st.swing[idx] = pwdata[SWING_W-1:0];
        tlc_pkg::ADDR_TX_BLOCK: next_st.blk[idx] = pwdata[0];
        tlc_pkg::ADDR_TX_INV:   next_st.tinv[idx] = pwdata[0];
        tlc_pkg::ADDR_RX_INV:   next_st.rinv[idx] = pwdata[0];
        tlc_pkg::ADDR_EQ_SEL:   next_st.eq[idx] = pwdata[0];
        tlc_pkg::ADDR_ADAPT_RST:
          next_st.adrst[idx] = pwdata[0];
        tlc_pkg::ADDR_HDR_LIMIT: begin
          // out of range values are dropped, old limit kept
          if (pwdata[3:0] >= tlc_pkg::HDR_LIMIT_MIN &&
              pwdata[3:0] <= tlc_pkg::HDR_LIMIT_MAX &&
              pwdata[31:4] == 28'h0000000) begin
            next_st.hdr[idx] = pwdata[3:0];
          end
        end
        tlc_pkg::ADDR_MB_WDATA: next_st.mb_wdata = pwdata[15:0];
        tlc_pkg::ADDR_MB_ADDR: begin
          // ignored while busy or when built without rate switching
          if (DYNAMIC_RATE && st.mb == MB_IDLE) begin
            next_st.mb_addr = pwdata[CFG_AW-1:0];
            if (pwdata[tlc_pkg::MB_WR_FLAG] ||
                pwdata[tlc_pkg::MB_RD_FLAG]) begin
              next_st.mb_go = 1'b1;
              next_st.mb    = MB_BUSY;
              next_st.mb_we = pwdata[tlc_pkg::MB_WR_FLAG];
            end
          end
        end
        default: next_st.sel = st.sel;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st       <= '0;
      st.mb    <= MB_IDLE;
      st.swing <= {LANES{SWING_W'(tlc_pkg::SWING_RST)}};
      st.blk   <= {LANES{tlc_pkg::TX_BLOCK_RST}};
      st.eq    <= {LANES{tlc_pkg::EQ_SEL_RST}};
      st.hdr   <= {LANES{tlc_pkg::HDR_LIMIT_RST}};
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs to the lanes and config port
  // ---------------------------------------------------------------
  assign tx_chan_reset       = st.tx_rst;
  assign rx_chan_reset       = st.rx_rst;
  assign tx_power_state      = st.pwr;
  assign tx_drive_swing      = st.swing;
  assign rx_equalizer_select = st.eq;
  assign rx_adapt_reset      = st.adrst;
  assign rx_bad_header_limit = st.hdr;
  assign cfg_en              = st.mb_go;
  assign cfg_we              = st.mb_we;
  assign cfg_sel             = st.sel;
  assign cfg_addr            = st.mb_addr;
  assign cfg_wdata           = st.mb_wdata;

  // one serial edge per lane
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    tlc_lane u_lane (
      .pclk            (pclk),
      .presetn         (presetn),
      .tx_bit          (tx_bit[g]),
      .tx_invert       (st.tinv[g]),
      .tx_output_block (st.blk[g]),
      .rx_line_pos     (rx_line_pos[g]),
      .rx_invert       (st.rinv[g]),
      .serial_out_pos  (serial_out_pos[g]),
      .serial_out_neg  (serial_out_neg[g]),
      .rx_bit          (rx_bit[g])
    );
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_setup_xing;
    psel && !penable && xing;
  endsequence

  sequence s_wr(logic [11:0] a);
    wr && paddr == a;
  endsequence

  AST_TX_RST_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr(tlc_pkg::ADDR_TX_RST) |=>
      tx_chan_reset == $past(pwdata[0]))
    else $error("tx reset does not follow write");

  AST_RX_RST_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr && paddr == tlc_pkg::ADDR_RX_RST) |=> $stable(rx_chan_reset))
    else $error("rx reset changed without a write");

  AST_SHARED_RST: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && (paddr == tlc_pkg::ADDR_TX_RST ||
                paddr == tlc_pkg::ADDR_RX_RST)) |-> !pslverr)
    else $error("shared reset refused");

  AST_PWR_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr(tlc_pkg::ADDR_TX_PWR) |=>
      tx_power_state[2*$past(idx) +: 2] == $past(pwdata[1:0]))
    else $error("tx power not stored");

  AST_XING_WAIT: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_setup_xing |=> (!pready)[*3] ##1 pready)
    else $error("lane access wait wrong");

  AST_HDR_RANGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_wr(tlc_pkg::ADDR_HDR_LIMIT) &&
     (pwdata[3:0] == 4'h0 || pwdata[3:0] > 4'h8))
      |=> $stable(rx_bad_header_limit))
    else $error("bad header limit accepted");

  AST_LANE_READ: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == tlc_pkg::ADDR_EQ_SEL &&
     sel_ok) |=> prdata[0] == rx_equalizer_select[$past(idx)])
    else $error("lane read returns wrong copy");

  AST_MB_LAUNCH: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_wr(tlc_pkg::ADDR_MB_ADDR) && st.mb == MB_IDLE &&
     pwdata[31]) |=> (cfg_en == DYNAMIC_RATE) && cfg_we)
    else $error("mailbox write not launched");

  AST_MB_OPTION: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_en |-> DYNAMIC_RATE ##1 !cfg_en)
    else $error("mailbox active without option");

endmodule : tlc_bank
`default_nettype wire

// >>> dv/tlc_cfg_model.sv
// tlc_cfg_model: behavioural config space behind the bank's mailbox.
// assumes cfg_* come from the bank on pclk; answers fast or slow.
`timescale 1ns/100ps
`default_nettype none
module tlc_cfg_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic        cfg_en,
  input  wire logic        cfg_we,
  input  wire logic [15:0] cfg_addr,
  input  wire logic [15:0] cfg_wdata,
  output logic      [15:0] cfg_rdata,
  output logic             cfg_rdy
);
  logic [15:0] mem [16];
  logic [3:0]  cnt;
  // ---------------------------------------------------------------
  // one op at a time, answered after 1 or 6 cycles
  // ---------------------------------------------------------------
  // idle read data toggles, so a stale capture never matches by luck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= 4'h0;
      cfg_rdy   <= 1'b0;
      cfg_rdata <= 16'h0;
    end else begin
      cfg_rdy   <= 1'b0;
      cfg_rdata <= ~cfg_rdata;
      if (cfg_en) begin
        cnt <= slow ? 4'h6 : 4'h1;
      end else if (cnt == 4'h1) begin
        cnt     <= 4'h0;
        cfg_rdy <= 1'b1;
        if (cfg_we) begin
          mem[cfg_addr[3:0]] <= cfg_wdata;
        end else begin
          cfg_rdata <= mem[cfg_addr[3:0]];
        end
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : tlc_cfg_model
`default_nettype wire

// >>> dv/testbench.sv
// testbench: apb driven checks of the lane control bank.
// assumes tlc_bank with 4 lanes and the config model on its port.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        pclk, pready, pslverr, cfg_en, cfg_we, cfg_rdy;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, slow = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [3:0]  tx_bit = 4'h0, rx_line_pos = 4'h0, serial_out_pos;
  logic [3:0]  serial_out_neg, rx_bit, rx_equalizer_select;
  logic [3:0]  rx_adapt_reset;
  logic        tx_chan_reset, rx_chan_reset, rerr;
  logic [7:0]  tx_power_state, cfg_sel;
  logic [15:0] tx_drive_swing, rx_bad_header_limit;
  logic [15:0] cfg_addr, cfg_wdata, cfg_rdata;
  int          nwait, n_mismatch = 0, num_checks = 0, cyc = 0;

  tlc_bank dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_bit, .rx_line_pos,
    .serial_out_pos, .serial_out_neg, .rx_bit, .tx_chan_reset,
    .rx_chan_reset, .tx_power_state, .tx_drive_swing,
    .rx_equalizer_select, .rx_adapt_reset, .rx_bad_header_limit,
    .cfg_en, .cfg_we, .cfg_sel, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .cfg_rdy);
  tlc_cfg_model far (.pclk, .presetn, .slow, .cfg_en, .cfg_we,
    .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_rdy);

  // ---------------------------------------------------------------
  // clock, hang guard and verdict
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // whole run is a few hundred cycles; far above that means a hang
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end
  task automatic summarize;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // ---------------------------------------------------------------
  // apb master: holds the request until pready, then releases
  // ---------------------------------------------------------------
  // answer taken at the transfer edge itself, before its updates land;
  // ends on a falling edge so outputs of that edge have settled
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    nwait = k - 1;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
    chk(rerr, 1'b0);
    if (a >= 12'h400) chk(nwait, 3);
  endtask : rc
  task automatic mbx(input logic [31:0] op);
    int k;
    wr(tlc_pkg::ADDR_MB_ADDR, op);
    k = 0;
    do begin
      apb(1'b0, tlc_pkg::ADDR_MB_STATUS, 32'h0);
      k++;
    end while (rdat[0] !== 1'b0 && k < 50);
    chk(rdat[0], 1'b0);
  endtask : mbx
  task automatic txc(input logic b, input logic [1:0] e);
    @(posedge pclk);
    tx_bit <= {2'b00, b, 1'b0};
    @(posedge pclk);
    @(negedge pclk);
    chk({serial_out_pos[1], serial_out_neg[1]}, e);
  endtask : txc
  task automatic rxc(input logic [3:0] v, input logic [3:0] e);
    @(posedge pclk);
    rx_line_pos <= v;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk(rx_bit, e);
  endtask : rxc
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int i;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(tx_power_state, 32'h0);
    chk(tx_drive_swing, 32'hcccc);
    chk(rx_equalizer_select, 32'hf);
    chk(rx_bad_header_limit, 32'h8888);
    chk({serial_out_pos, serial_out_neg}, 32'h0f);
    rc(tlc_pkg::ADDR_LANE_COUNT, 32'h4);
    rc(tlc_pkg::ADDR_TX_RST, 32'h0);
    rc(tlc_pkg::ADDR_RX_RST, 32'h0);
    rc(tlc_pkg::ADDR_TX_INV, 32'h0);
    rc(tlc_pkg::ADDR_RX_INV, 32'h0);
    rc(tlc_pkg::ADDR_EQ_SEL, 32'h1);
    rc(tlc_pkg::ADDR_ADAPT_RST, 32'h0);
    rc(tlc_pkg::ADDR_TX_BLOCK, 32'h0);
    // each lane keeps its own copy; read back in reverse order
    for (i = 0; i < 4; i++) begin
      wr(tlc_pkg::ADDR_LANE_SEL, i);
      wr(tlc_pkg::ADDR_TX_PWR, i);
      wr(tlc_pkg::ADDR_SWING, i + 1);
      wr(tlc_pkg::ADDR_EQ_SEL, i % 2);
      wr(tlc_pkg::ADDR_HDR_LIMIT, 8 - i);
    end
    for (i = 3; i >= 0; i--) begin
      wr(tlc_pkg::ADDR_LANE_SEL, i);
      rc(tlc_pkg::ADDR_TX_PWR, i);
      rc(tlc_pkg::ADDR_SWING, i + 1);
      rc(tlc_pkg::ADDR_EQ_SEL, i % 2);
      rc(tlc_pkg::ADDR_HDR_LIMIT, 8 - i);
    end
    chk(tx_power_state, 32'he4);
    chk(tx_drive_swing, 32'h4321);
    chk(rx_equalizer_select, 32'ha);
    chk(rx_bad_header_limit, 32'h5678);
    // out-of-range limits are dropped, lane 0 still holds 8
    wr(tlc_pkg::ADDR_HDR_LIMIT, 32'h0);
    wr(tlc_pkg::ADDR_HDR_LIMIT, 32'h9);
    wr(tlc_pkg::ADDR_HDR_LIMIT, 32'h11);
    rc(tlc_pkg::ADDR_HDR_LIMIT, 32'h8);
    wr(tlc_pkg::ADDR_HDR_LIMIT, 32'h1);
    rc(tlc_pkg::ADDR_HDR_LIMIT, 32'h1);
    // mode change followed by an adaptation reset pulse
    wr(tlc_pkg::ADDR_EQ_SEL, 32'h1);
    chk(rx_equalizer_select, 32'hb);
    wr(tlc_pkg::ADDR_ADAPT_RST, 32'h1);
    chk(rx_adapt_reset, 32'h1);
    wr(tlc_pkg::ADDR_ADAPT_RST, 32'h0);
    chk(rx_adapt_reset, 32'h0);
    // shared resets answer with any select value, lane regs refuse
    wr(tlc_pkg::ADDR_LANE_SEL, 32'hc8);
    wr(tlc_pkg::ADDR_TX_RST, 32'h1);
    chk(rerr, 1'b0);
    chk({tx_chan_reset, rx_chan_reset}, 32'h2);
    wr(tlc_pkg::ADDR_RX_RST, 32'h1);
    chk({tx_chan_reset, rx_chan_reset}, 32'h3);
    rc(tlc_pkg::ADDR_TX_RST, 32'h1);
    apb(1'b0, tlc_pkg::ADDR_TX_PWR, 32'h0);
    chk(rerr, 1'b1);
    apb(1'b0, 12'h7f0, 32'h0);
    chk({rerr, nwait[3:0]}, 32'h10);
    wr(tlc_pkg::ADDR_TX_RST, 32'h0);
    wr(tlc_pkg::ADDR_RX_RST, 32'h0);
    chk({tx_chan_reset, rx_chan_reset}, 32'h0);
    // lane 1 serial output: invert, then inhibit over invert
    wr(tlc_pkg::ADDR_LANE_SEL, 32'h1);
    txc(1'b1, 2'b10);
    wr(tlc_pkg::ADDR_TX_INV, 32'h1);
    txc(1'b1, 2'b01);
    txc(1'b0, 2'b10);
    wr(tlc_pkg::ADDR_TX_BLOCK, 32'h1);
    txc(1'b1, 2'b01);
    txc(1'b0, 2'b01);
    // lane 2 inverts incoming data, others pass it straight
    wr(tlc_pkg::ADDR_LANE_SEL, 32'h2);
    wr(tlc_pkg::ADDR_RX_INV, 32'h1);
    rxc(4'hf, 4'hb);
    rxc(4'h0, 4'h4);
    // mailbox write then read back, then read-modify-write
    wr(tlc_pkg::ADDR_MB_WDATA, 32'h1234);
    mbx(32'h8000_0005);
    chk({cfg_addr, cfg_wdata}, 32'h0005_1234);
    chk(cfg_sel, 32'h2);
    chk(cfg_we, 1'b1);
    @(posedge pclk);
    slow <= 1'b1;
    mbx(32'h4000_0005);
    chk(cfg_we, 1'b0);
    rc(tlc_pkg::ADDR_MB_RDATA, 32'h1234);
    wr(tlc_pkg::ADDR_MB_WDATA, rdat | 32'h00f0);
    mbx(32'h8000_0005);
    // second launch lands while busy and must be ignored
    wr(tlc_pkg::ADDR_MB_ADDR, 32'h4000_0005);
    mbx(32'h8000_0009);
    chk(cfg_addr, 32'h5);
    rc(tlc_pkg::ADDR_MB_RDATA, 32'h12f4);
    // rate change tail: park the unused tx side, then pulse rx reset
    wr(tlc_pkg::ADDR_LANE_SEL, 32'h0);
    wr(tlc_pkg::ADDR_TX_PWR, 32'h3);
    chk(tx_power_state, 32'he7);
    wr(tlc_pkg::ADDR_RX_RST, 32'h1);
    chk(rx_chan_reset, 1'b1);
    wr(tlc_pkg::ADDR_RX_RST, 32'h0);
    chk(rx_chan_reset, 1'b0);
    summarize();
  end
endmodule : testbench
`default_nettype wire
